//--- core/xpcfg_core.sv
/*
  crosspoint configuration port: serial link, pending load register and
  the active per-output routing registers with reset and broadcast pins.
  assumes: the host serial clock is a separate, unrelated clock; the
  configure strobe stays low while bits are shifted, so the load register
  is quiet whenever it is captured.
*/
`timescale 1ns/10ps
`default_nettype none
`include "xpcfg_map.svh"

module xpcfg_core #(
  parameter int NUM_OUT = `XPCFG_NUM_OUT,
  parameter int SEL_W = `XPCFG_SEL_W
) (
  input wire logic REF_CLK_IN,                     // system clock, 125 MHz
  input wire logic RST_IN,                         // asynchronous reset, active high
  input wire logic CE_IN,                          // clock enable, freezes system-clock state when low
  input wire logic SCLK_IN,                        // host serial clock
  input wire logic SCS_N_IN,                       // chip select, active low
  input wire logic SDI_IN,                         // serial data in
  output logic SDO_OUT,                            // serial data out to next device
  input wire logic MODE_IN,                        // high: addressed mode
  input wire logic CFG_IN,                         // configure strobe, active high
  input wire logic MATRIX_RST_IN,                  // matrix reset pin, level
  input wire logic BROADCAST_ALL_INPUT0_IN,        // broadcast pin, level
  output logic [NUM_OUT*SEL_W-1:0] ROUTE_SEL_OUT,  // input selected per output
  output logic [NUM_OUT-1:0] OUT_OFF_OUT,          // output off (high impedance)
  output logic PENDING_OUT                         // new bits waiting for configure
);

  localparam int FRAME_W = NUM_OUT * `XPCFG_SLOT_W;

  // refuse geometries the frame and word layouts cannot carry
  if (NUM_OUT < 1 || NUM_OUT > (1 << `XPCFG_WORD_OADDR_W))
  begin : g_bad_num_out
    $error("NUM_OUT out of range");
  end
  if (SEL_W != `XPCFG_SEL_W)
  begin : g_bad_sel_w
    $error("SEL_W must match the slot layout");
  end

  // all core state
  typedef struct packed {
    logic [`XPCFG_SYNC_W-1:0] s1;           // synchroniser stage one
    logic [`XPCFG_SYNC_W-1:0] s2;           // stage two
    logic [`XPCFG_SYNC_W-1:0] s3;           // stage three
    logic [`XPCFG_SYNC_W-1:0] flt;          // filtered levels
    logic tog_seen;                         // last link toggle accounted for
    logic dirty;                            // new bits since last apply
    logic cfg_prev;                         // configure level one cycle ago
    xpcfg_pkg::xpcfg_state_t st;            // apply sequencer
    logic cap_mode;                         // mode at capture
    logic [FRAME_W-1:0] cap;                // captured load register
    logic [NUM_OUT*SEL_W-1:0] sel;          // active input selects
    logic [NUM_OUT-1:0] off;                // active off flags
  } xpcfg_core_st_t;

  xpcfg_core_st_t q;                        // registered state
  xpcfg_core_st_t d;                        // next state
  logic [FRAME_W-1:0] link_load;            // load register from link domain
  logic link_tog;                           // bit toggle from link domain
  logic link_sdo;                           // serial out flop from link domain

  // input select field of slot n in a serial frame
  function automatic logic [SEL_W-1:0] slot_sel(input logic [FRAME_W-1:0] f,
                                                input int n);
    slot_sel = f[n*`XPCFG_SLOT_W +: SEL_W];
  endfunction : slot_sel

  // off flag of slot n in a serial frame
  function automatic logic slot_off(input logic [FRAME_W-1:0] f, input int n);
    slot_off = f[n*`XPCFG_SLOT_W + `XPCFG_SLOT_OFF_BIT];
  endfunction : slot_off

  // link domain: load shift register and serial out
  xpcfg_link #(
    .FRAME_W(FRAME_W)
  ) u_link (
    .sclk_in(SCLK_IN),
    .rst_in(RST_IN),
    .cs_n_in(SCS_N_IN),
    .sdi_in(SDI_IN),
    .mode_in(MODE_IN),
    .sdo_out(link_sdo),
    .load_out(link_load),
    .tog_out(link_tog)
  );

  // next state of the core
  always_comb
  begin
    logic [`XPCFG_WORD_W-1:0] word;         // addressed word from the capture
    logic [`XPCFG_WORD_OADDR_W-1:0] oaddr;  // output address of the word
    logic cfg_rise;                         // filtered configure rising edge
    logic news;                             // link toggle changed
    word = '0;
    oaddr = '0;
    cfg_rise = 1'h0;
    news = 1'h0;
    d = q;
    // three-flop synchronisers; a change counts once stages two and three agree
    d.s1 = {link_tog, BROADCAST_ALL_INPUT0_IN, MATRIX_RST_IN, MODE_IN, CFG_IN};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
    cfg_rise = q.flt[`XPCFG_SYNC_CFG] & ~q.cfg_prev;
    d.cfg_prev = q.flt[`XPCFG_SYNC_CFG];
    news = q.flt[`XPCFG_SYNC_TOG] != q.tog_seen;
    d.tog_seen = q.flt[`XPCFG_SYNC_TOG];
    // apply sequencer
    case (q.st)
      xpcfg_pkg::XPCFG_ST_IDLE:
      begin
        // a pulse with nothing new is ignored
        if (cfg_rise && q.dirty)
        begin
          d.dirty = 1'h0;
          d.st = xpcfg_pkg::XPCFG_ST_LOAD;
        end
        else if (cfg_rise)
        begin
          d.st = xpcfg_pkg::XPCFG_ST_HOLD;
        end
      end
      xpcfg_pkg::XPCFG_ST_LOAD:
      begin
        // load register is quiet here: configure is only raised after shifting
        d.cap = link_load;
        d.cap_mode = q.flt[`XPCFG_SYNC_MODE];
        d.st = xpcfg_pkg::XPCFG_ST_APPLY;
      end
      xpcfg_pkg::XPCFG_ST_APPLY:
      begin
        if (!q.cap_mode)
        begin
          // serial mode: whole frame, six bits per output
          for (int i = 0; i < NUM_OUT; i++)
          begin
            d.sel[i*SEL_W +: SEL_W] = slot_sel(q.cap, i);
            d.off[i] = slot_off(q.cap, i);
          end
        end
        else
        begin
          // addressed mode: last ten bits shifted, first of them at the bottom
          word = q.cap[FRAME_W-1 -: `XPCFG_WORD_W];
          oaddr = word[`XPCFG_WORD_OADDR_LSB +: `XPCFG_WORD_OADDR_W];
          for (int i = 0; i < NUM_OUT; i++)
          begin
            // only the addressed output changes
            if (oaddr == i[`XPCFG_WORD_OADDR_W-1:0])
            begin
              d.sel[i*SEL_W +: SEL_W] = word[`XPCFG_WORD_IADDR_LSB +: SEL_W];
              d.off[i] = word[`XPCFG_WORD_OFF_BIT];
            end
          end
        end
        d.st = xpcfg_pkg::XPCFG_ST_HOLD;
      end
      xpcfg_pkg::XPCFG_ST_HOLD:
      begin
        // wait for the strobe to fall before the next pulse counts
        if (!q.flt[`XPCFG_SYNC_CFG])
        begin
          d.st = xpcfg_pkg::XPCFG_ST_IDLE;
        end
      end
      default:
      begin
        d.st = xpcfg_pkg::XPCFG_ST_IDLE;
      end
    endcase
    // new bits set the pending flag; set wins over the clear above
    if (news)
    begin
      d.dirty = 1'h1;
    end
    // level overrides win over any apply; reset before broadcast
    if (q.flt[`XPCFG_SYNC_MRST])
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        d.sel[i*SEL_W +: SEL_W] = `XPCFG_RST_SEL;
        d.off[i] = `XPCFG_RST_OFF;
      end
    end
    else if (q.flt[`XPCFG_SYNC_BROADCAST])
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        d.sel[i*SEL_W +: SEL_W] = `XPCFG_BROADCAST_SEL;
        d.off[i] = `XPCFG_BROADCAST_OFF;
      end
    end
  end

  // register the core state; clock enable freezes all of it, while the link domain keeps running
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      q <= '{s1: '0, s2: '0, s3: '0, flt: '0, tog_seen: 1'h0, dirty: 1'h0,
             cfg_prev: 1'h0, st: xpcfg_pkg::XPCFG_ST_IDLE, cap_mode: 1'h0,
             cap: '0, sel: '0, off: '1};
    end
    else if (CE_IN)
    begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign ROUTE_SEL_OUT = q.sel;
  assign OUT_OFF_OUT = q.off;
  assign PENDING_OUT = q.dirty;
  assign SDO_OUT = link_sdo;

endmodule : xpcfg_core

`default_nettype wire

//--- core/xpcfg_link.sv
/*
  link side of the configuration port: the load shift register, clocked by
  the falling edge of the host serial clock, and the serial data output.
  assumes: the host changes chip select only while the serial clock is low;
  the serial clock may stop outside frames.
*/
`timescale 1ns/10ps
`default_nettype none
`include "xpcfg_map.svh"

module xpcfg_link #(
  parameter int FRAME_W = `XPCFG_FRAME_W
) (
  input wire logic sclk_in,                // host serial clock
  input wire logic rst_in,                 // asynchronous reset, active high
  input wire logic cs_n_in,                // chip select, active low
  input wire logic sdi_in,                 // serial data in
  input wire logic mode_in,                // addressed mode when high, from a pin
  output logic sdo_out,                    // serial data out, registered
  output logic [FRAME_W-1:0] load_out,     // load register contents
  output logic tog_out                     // toggles on every accepted bit
);

  // all link state
  typedef struct packed {
    logic [FRAME_W-1:0] sr;                // load shift register
    logic tog;                             // bit-accepted toggle
    logic [`XPCFG_MSYNC_W-1:0] ms;         // mode synchroniser
    logic mflt;                            // filtered mode level
    logic dout;                            // serial out flop
  } xpcfg_link_st_t;

  xpcfg_link_st_t q;                       // registered state
  xpcfg_link_st_t d;                       // next state

  // next state on each falling serial clock edge
  always_comb
  begin
    d = q;
    // mode passes three flops; a change counts once stages two and three agree
    d.ms = {q.ms[`XPCFG_MSYNC_W-2:0], mode_in};
    if (q.ms[1] == q.ms[2])
    begin
      d.mflt = q.ms[2];
    end
    // a falling edge with select low was preceded by a rising edge with
    // select low, since select only moves while the clock is low
    if (!cs_n_in)
    begin
      // shift right, new bit enters at the top; oldest bit leaves at bit 0
      d.sr = {sdi_in, q.sr[FRAME_W-1:1]};
      d.tog = ~q.tog;
      // stale contents leave first, the new frame follows after a full frame
      d.dout = q.mflt ? 1'h0 : q.sr[1];
    end
    else
    begin
      // select high: data ignored, load register and toggle hold; serial out takes bit 0
      d.sr = q.sr;
      d.dout = q.mflt ? 1'h0 : q.sr[0];
    end
  end

  // register the link state on the falling edge
  always_ff @(negedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign sdo_out = q.dout;
  assign load_out = q.sr;
  assign tog_out = q.tog;

endmodule : xpcfg_link

`default_nettype wire

//--- inc/xpcfg_map.svh
/*
  constants of the crosspoint configuration port: frame layout, addressed
  word layout, override values and input synchroniser bit positions.
  assumes: included by bare name from the design modules.
*/
`ifndef XPCFG_MAP_SVH
`define XPCFG_MAP_SVH

// frame and slot layout
`define XPCFG_NUM_OUT 16
`define XPCFG_SEL_W 5
`define XPCFG_SLOT_W 6
`define XPCFG_SLOT_OFF_BIT 5
`define XPCFG_FRAME_W 96

// addressed word layout, bit 0 shifted in first
`define XPCFG_WORD_W 10
`define XPCFG_WORD_OADDR_LSB 0
`define XPCFG_WORD_OADDR_W 4
`define XPCFG_WORD_IADDR_LSB 4
`define XPCFG_WORD_OFF_BIT 9

// override and reset values
`define XPCFG_RST_SEL 5'h00
`define XPCFG_RST_OFF 1'h1
`define XPCFG_BROADCAST_SEL 5'h00
`define XPCFG_BROADCAST_OFF 1'h0

// positions of pin inputs and the link toggle in the synchroniser vector
`define XPCFG_SYNC_W 5
`define XPCFG_SYNC_CFG 0
`define XPCFG_SYNC_MODE 1
`define XPCFG_SYNC_MRST 2
`define XPCFG_SYNC_BROADCAST 3
`define XPCFG_SYNC_TOG 4

// mode synchroniser depth in the link domain
`define XPCFG_MSYNC_W 3

`endif

//--- inc/xpcfg_pkg.sv
/*
  types of the crosspoint configuration port.
  assumes: compiled before the design modules; constants come from the map.
*/
package xpcfg_pkg;

  // apply sequencer states, gray coded along idle-load-apply-hold
  typedef enum logic [1:0] {
    XPCFG_ST_IDLE = 2'h0,
    XPCFG_ST_LOAD = 2'h1,
    XPCFG_ST_APPLY = 2'h3,
    XPCFG_ST_HOLD = 2'h2
  } xpcfg_state_t;

endpackage : xpcfg_pkg

//--- test/xpcfg_core_assertions.sv
/* checker of the configuration port outputs.
   assumes: bound to xpcfg_core; serial clock idles low between frames. */
`timescale 1ns/10ps
`default_nettype none
module xpcfg_core_chk #(
  parameter int NUM_OUT = 16,
  parameter int SEL_W = 5
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic SCLK_IN,
  input wire logic SCS_N_IN,
  input wire logic SDI_IN,
  input wire logic SDO_OUT,
  input wire logic MODE_IN,
  input wire logic CFG_IN,
  input wire logic MATRIX_RST_IN,
  input wire logic BROADCAST_ALL_INPUT0_IN,
  input wire logic [NUM_OUT*SEL_W-1:0] ROUTE_SEL_OUT,
  input wire logic [NUM_OUT-1:0] OUT_OFF_OUT,
  input wire logic PENDING_OUT
);
  logic [7:0] run_q; // unbroken selected falling edges in serial mode
  // counts the run so the shift delay through the load register is known
  always_ff @(negedge SCLK_IN or posedge RST_IN)
    if (RST_IN) run_q <= 8'h00;
    else if (SCS_N_IN || MODE_IN) run_q <= 8'h00;
    else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
  // the core's system-clock state is frozen while its clock enable is low, so those checks rest then; the serial out checks do not
  chk_rst_force: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN || !CE_IN)
    MATRIX_RST_IN [*6] |-> ROUTE_SEL_OUT == '0 && &OUT_OFF_OUT)
    else $error("reset pin did not turn outputs off");
  chk_broadcast_force: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN || !CE_IN)
    (BROADCAST_ALL_INPUT0_IN && !MATRIX_RST_IN) [*6] |-> ROUTE_SEL_OUT == '0 && OUT_OFF_OUT == '0)
    else $error("broadcast pin did not turn outputs on");
  chk_idle_stable: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN || !CE_IN)
    (!PENDING_OUT && !MATRIX_RST_IN && !BROADCAST_ALL_INPUT0_IN) [*6]
    |=> $stable(ROUTE_SEL_OUT) && $stable(OUT_OFF_OUT))
    else $error("outputs changed with nothing pending");
  chk_pend_hold: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN || !CE_IN)
    !CFG_IN [*6] ##0 PENDING_OUT |=> PENDING_OUT)
    else $error("pending flag lost without configure");
  chk_pend_clear: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN || !CE_IN)
    PENDING_OUT && $rose(CFG_IN) ##1 CFG_IN [*3] |-> ##[1:6] !PENDING_OUT)
    else $error("configure pulse did not take pending settings");
  chk_cfg_wait: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN || !CE_IN)
    $rose(CFG_IN) && !MATRIX_RST_IN && !BROADCAST_ALL_INPUT0_IN
    |=> $stable(ROUTE_SEL_OUT) && $stable(OUT_OFF_OUT))
    else $error("outputs changed before configure was filtered");
  chk_sdo_quiet: assert property (@(negedge SCLK_IN) disable iff (RST_IN)
    MODE_IN [*6] |-> !SDO_OUT)
    else $error("serial out active in addressed mode");
  chk_sdo_delay: assert property (@(negedge SCLK_IN) disable iff (RST_IN)
    run_q >= 8'h60 |-> SDO_OUT == $past(SDI_IN, 96))
    else $error("serial out not delayed by one frame");
endmodule : xpcfg_core_chk
bind xpcfg_core xpcfg_core_chk #(.NUM_OUT(NUM_OUT), .SEL_W(SEL_W)) u_chk (
  .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN), .SCLK_IN(SCLK_IN),
  .SCS_N_IN(SCS_N_IN),
  .SDI_IN(SDI_IN), .SDO_OUT(SDO_OUT), .MODE_IN(MODE_IN), .CFG_IN(CFG_IN),
  .MATRIX_RST_IN(MATRIX_RST_IN), .BROADCAST_ALL_INPUT0_IN(BROADCAST_ALL_INPUT0_IN),
  .ROUTE_SEL_OUT(ROUTE_SEL_OUT), .OUT_OFF_OUT(OUT_OFF_OUT), .PENDING_OUT(PENDING_OUT));
`default_nettype wire

//--- test/xpcfg_core_tb_top.sv
/* testbench of the configuration port: host model on the link, pins
   driven on the system clock, routing outputs compared.
   assumes: the checker binds itself to the core. */
`timescale 1ns/10ps
`default_nettype none
module xpcfg_core_tb_top;
  logic ref_clk = 1'b0; // system clock
  logic rst = 1'b1; // reset
  logic mode = 1'b0; // addressed mode
  logic cfg = 1'b0; // configure strobe
  logic mrst = 1'b0; // matrix reset pin
  logic bcast_all = 1'b0; // broadcast pin
  logic ce = 1'b1; // clock enable of the core
  logic sclk, scs_n, sdi, sdo, pend; // link pins and pending flag
  logic [79:0] route, exp_route; // selects
  logic [15:0] off, exp_off; // off flags
  logic [95:0] frame; // serial frame
  logic [9:0] w; // addressed word
  int n_fail = 0;
  int compares = 0;
  // 125 MHz clock
  initial forever #4 ref_clk = ~ref_clk;
  xpcfg_core uut (.REF_CLK_IN(ref_clk), .RST_IN(rst), .CE_IN(ce), .SCLK_IN(sclk),
    .SCS_N_IN(scs_n), .SDI_IN(sdi), .SDO_OUT(sdo), .MODE_IN(mode), .CFG_IN(cfg),
    .MATRIX_RST_IN(mrst), .BROADCAST_ALL_INPUT0_IN(bcast_all), .ROUTE_SEL_OUT(route),
    .OUT_OFF_OUT(off), .PENDING_OUT(pend));
  xpcfg_host_model host (.sclk_out(sclk), .scs_n_out(scs_n), .sdi_out(sdi));
  // compares one result
  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // compares both routing outputs
  task automatic expect_out();
    check(route, exp_route);
    check({64'h0, off}, {64'h0, exp_off});
  endtask : expect_out
  // waits n edges, then steps just past
  task automatic waits(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : waits
  // configure pulse of four cycles, then time to apply
  task automatic pulse_cfg();
    waits(1);
    cfg = 1'b1;
    waits(4);
    cfg = 1'b0;
    waits(12);
  endtask : pulse_cfg
  // verdict and end of run
  task automatic complete_run();
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // watchdog
  initial
  begin
    #400000;
    n_fail++;
    complete_run();
  end
  // main sequence
  initial
  begin
    waits(4);
    rst = 1'b0;
    exp_route = '0;
    exp_off = 16'hFFFF;
    expect_out();
    host.noise(4);
    waits(10);
    check({79'h0, pend}, 80'h0);
    // serial frame: selects 31, 29 .. 1, odd outputs off
    for (int n = 0; n < 16; n++)
    begin
      frame[6*n +: 6] = {n[0], 5'(31 - 2 * n)};
      exp_route[5*n +: 5] = 5'(31 - 2 * n);
      exp_off[n] = n[0];
    end
    host.send({frame, ~frame});
    waits(10);
    check({79'h0, pend}, 80'h1);
    check(route, 80'h0);
    // deselected serial out shows the oldest bit still in the load register
    check({79'h0, sdo}, {79'h0, frame[0]});
    pulse_cfg();
    expect_out();
    check({79'h0, pend}, 80'h0);
    pulse_cfg();
    expect_out();
    // addressed words: output 5 on from 19, output 15 off from 31
    mode = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      w = (k == 0) ? 10'h135 : 10'h3FF;
      host.send({w, 182'h0});
      waits(10);
      check({79'h0, sdo}, 80'h0);
      pulse_cfg();
      exp_route[5*w[3:0] +: 5] = w[8:4];
      exp_off[w[3:0]] = w[9];
      expect_out();
    end
    mode = 1'b0;
    // clock enable low freezes the core: a reset pin pulse leaves no trace
    ce = 1'b0;
    mrst = 1'b1;
    waits(8);
    mrst = 1'b0;
    waits(8);
    ce = 1'b1;
    waits(8);
    expect_out();
    // overrides: reset wins over broadcast, then broadcast alone
    mrst = 1'b1;
    bcast_all = 1'b1;
    waits(8);
    exp_route = '0;
    exp_off = 16'hFFFF;
    expect_out();
    mrst = 1'b0;
    waits(8);
    exp_off = 16'h0000;
    expect_out();
    bcast_all = 1'b0;
    waits(8);
    expect_out();
    complete_run();
  end
endmodule : xpcfg_core_tb_top
`default_nettype wire

//--- test/xpcfg_host_model.sv
/* host model driving the serial programming pins.
   assumes: 80 ns serial clock that stands low outside frames. */
`timescale 1ns/10ps
`default_nettype none
module xpcfg_host_model (
  output logic sclk_out, // serial clock
  output logic scs_n_out, // chip select, active low
  output logic sdi_out // serial data
);
  // idle: clock low, deselected
  initial
  begin
    sclk_out = 1'b0;
    scs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // shifts 192 bits, bit 0 first, then deselects and gives one more rise
  task automatic send(input logic [191:0] bits);
    scs_n_out = 1'b0;
    sdi_out = bits[0];
    #40 sclk_out = 1'b1;
    for (int i = 0; i < 192; i++)
    begin
      #40 sclk_out = 1'b0;
      #5;
      if (i == 191) scs_n_out = 1'b1;
      sdi_out = (i == 191) ? ~bits[191] : bits[i + 1];
      #35 sclk_out = 1'b1;
    end
    #40 sclk_out = 1'b0;
  endtask : send
  // clock and data activity while deselected
  task automatic noise(input int n);
    for (int i = 0; i < n; i++)
    begin
      #40 sclk_out = 1'b1;
      sdi_out = ~sdi_out;
      #40 sclk_out = 1'b0;
    end
  endtask : noise
endmodule : xpcfg_host_model
`default_nettype wire
